// ---- jtb_pkg.sv ----
// shared constants and types for the jtag test access port
`default_nettype none
package jtb_pkg;

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  localparam int IR_W = 3;
  localparam logic [IR_W-1:0] OP_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] OP_SAMPLE = 3'h1;
  localparam logic [IR_W-1:0] OP_IDCODE = 3'h2;
  localparam logic [IR_W-1:0] OP_SINGLE_CHAIN = 3'h3;
  localparam logic [IR_W-1:0] OP_BYPASS = 3'h7;
  // fixed pattern loaded in capture-ir
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

  // ----------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------
  localparam int ID_W = 32;
  // identification value is arbitrary
  localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0A5C_3001;
  localparam logic BYPASS_CAPTURE = 1'b0;
  localparam logic [2:0] HI_CNT_TLR = 3'h5;

  // data register select codes
  localparam logic [1:0] SEL_BYP = 2'h0;
  localparam logic [1:0] SEL_ID = 2'h1;
  localparam logic [1:0] SEL_BSR = 2'h2;

  typedef logic [IR_W-1:0] jtb_ir_t;

  typedef enum logic [3:0] {
    S_TLR, S_RTI,
    S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR, S_UPD_DR,
    S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UPD_IR
  } jtb_state_e;

endpackage

`default_nettype wire

// ---- jtb_tap.sv ----
// jtag test access port with bypass, id and boundary scan registers
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module jtb_tap #(
  parameter int NIN = 16,
  parameter int NOUT = 16,
  parameter logic [jtb_pkg::ID_W-1:0] ID_CODE = jtb_pkg::ID_DEFAULT
) (
  input wire logic clk_sys, // core clock
  input wire logic rst, // core reset, async high
  input wire logic tck, // test clock
  input wire logic trst_n, // test reset, async low
  input wire logic tms, // mode select
  input wire logic tdi, // serial data in
  output logic tdo, // serial data out
  output logic tdo_oe, // tdo drive enable
  input wire logic [NIN-1:0] pad_in, // device input pins
  input wire logic [NOUT-1:0] core_out, // functional output values
  output logic [NOUT-1:0] pad_out // device output pins
);
  import jtb_pkg::*;

  localparam int BSR_W = NIN + NOUT;

  if (NIN < 1 || NOUT < 1 || BSR_W < ID_W) begin : g_bad
    $error("boundary chain shorter than id code");
  end

  function automatic logic [1:0] dr_sel(input jtb_ir_t ir);
    if (ir == OP_IDCODE) begin
      return SEL_ID;
    end else if (ir == OP_EXTEST || ir == OP_SAMPLE ||
                 ir == OP_SINGLE_CHAIN) begin
      return SEL_BSR;
    end
    return SEL_BYP;
  endfunction

  logic tap_rst;
  assign tap_rst = rst | ~trst_n;

  // ----------------------------------------------------------------
  // rising tck: controller and shift paths
  // ----------------------------------------------------------------
  jtb_state_e state_ff, nxt_state;
  jtb_ir_t ir_ff, ir_sr_ff, nxt_ir_sr;
  logic byp_ff, nxt_byp;
  logic [ID_W-1:0] id_ff, nxt_id;
  logic [BSR_W-1:0] bsr_ff, nxt_bsr;
  logic [NIN-1:0] in_m_ff, in_s_ff;
  logic [NOUT-1:0] out_m_ff, out_s_ff, pad_out_ff;
  logic [2:0] hi_cnt_ff, nxt_hi_cnt;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_TLR: nxt_state = tms ? S_TLR : S_RTI;
      S_RTI: nxt_state = tms ? S_SEL_DR : S_RTI;
      S_SEL_DR: nxt_state = tms ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: nxt_state = tms ? S_EX1_DR : S_SH_DR;
      S_SH_DR: nxt_state = tms ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: nxt_state = tms ? S_UPD_DR : S_PA_DR;
      S_PA_DR: nxt_state = tms ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: nxt_state = tms ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: nxt_state = tms ? S_SEL_DR : S_RTI;
      S_SEL_IR: nxt_state = tms ? S_TLR : S_CAP_IR;
      S_CAP_IR: nxt_state = tms ? S_EX1_IR : S_SH_IR;
      S_SH_IR: nxt_state = tms ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: nxt_state = tms ? S_UPD_IR : S_PA_IR;
      S_PA_IR: nxt_state = tms ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: nxt_state = tms ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: nxt_state = tms ? S_SEL_DR : S_RTI;
    endcase
  end

  always_comb begin
    nxt_ir_sr = ir_sr_ff;
    nxt_byp = byp_ff;
    nxt_id = id_ff;
    nxt_bsr = bsr_ff;
    // pause and other states fall through holding all paths
    if (state_ff == S_CAP_IR) begin
      nxt_ir_sr = IR_CAPTURE;
    end else if (state_ff == S_SH_IR) begin
      nxt_ir_sr = {tdi, ir_sr_ff[IR_W-1:1]};
    end else if (state_ff == S_CAP_DR) begin
      nxt_byp = BYPASS_CAPTURE;
      if (ir_ff == OP_IDCODE) begin
        nxt_id = ID_CODE;
      end
      if (ir_ff == OP_EXTEST) begin
        nxt_bsr[NIN-1:0] = in_s_ff;
      end
      if (ir_ff == OP_SAMPLE) begin
        nxt_bsr = {out_s_ff, in_s_ff};
      end
      if (ir_ff == OP_SINGLE_CHAIN) begin
        nxt_bsr = '0;
        nxt_bsr[ID_W-1:0] = ID_CODE;
      end
    end else if (state_ff == S_SH_DR) begin
      if (dr_sel(ir_ff) == SEL_ID) begin
        nxt_id = {tdi, id_ff[ID_W-1:1]};
      end else if (dr_sel(ir_ff) == SEL_BSR) begin
        nxt_bsr = {tdi, bsr_ff[BSR_W-1:1]};
      end else begin
        nxt_byp = tdi;
      end
    end
    nxt_hi_cnt = hi_cnt_ff;
    if (!tms) begin
      nxt_hi_cnt = '0;
    end else if (hi_cnt_ff != HI_CNT_TLR) begin
      nxt_hi_cnt = hi_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge tck or posedge tap_rst) begin
    if (tap_rst) begin
      state_ff <= S_TLR;
      ir_sr_ff <= '0;
      byp_ff <= 1'b0;
      id_ff <= '0;
      bsr_ff <= '0;
      in_m_ff <= '0;
      in_s_ff <= '0;
      out_m_ff <= '0;
      out_s_ff <= '0;
      hi_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      ir_sr_ff <= nxt_ir_sr;
      byp_ff <= nxt_byp;
      id_ff <= nxt_id;
      bsr_ff <= nxt_bsr;
      in_m_ff <= pad_in;
      in_s_ff <= in_m_ff;
      out_m_ff <= pad_out_ff;
      out_s_ff <= out_m_ff;
      hi_cnt_ff <= nxt_hi_cnt;
    end
  end

  // ----------------------------------------------------------------
  // falling tck: instruction, update latches, tdo
  // ----------------------------------------------------------------
  jtb_ir_t nxt_ir;
  logic [NOUT-1:0] upd_ff, nxt_upd;
  logic upd_tgl_ff, nxt_upd_tgl;
  logic extest_ff, nxt_extest;
  logic tdo_ff, nxt_tdo, tdo_oe_ff, nxt_tdo_oe;

  always_comb begin
    nxt_ir = ir_ff;
    if (state_ff == S_TLR) begin
      nxt_ir = OP_IDCODE;
    end else if (state_ff == S_UPD_IR) begin
      nxt_ir = ir_sr_ff;
    end
    nxt_extest = (nxt_ir == OP_EXTEST);
    nxt_upd = upd_ff;
    nxt_upd_tgl = upd_tgl_ff;
    if (state_ff == S_UPD_DR && dr_sel(ir_ff) == SEL_BSR) begin
      nxt_upd = bsr_ff[BSR_W-1:NIN];
      nxt_upd_tgl = ~upd_tgl_ff;
    end
    nxt_tdo_oe = (state_ff == S_SH_DR) || (state_ff == S_SH_IR);
    nxt_tdo = tdo_ff;
    if (state_ff == S_SH_IR) begin
      nxt_tdo = ir_sr_ff[0];
    end else if (state_ff == S_SH_DR) begin
      if (dr_sel(ir_ff) == SEL_ID) begin
        nxt_tdo = id_ff[0];
      end else if (dr_sel(ir_ff) == SEL_BSR) begin
        nxt_tdo = bsr_ff[0];
      end else begin
        nxt_tdo = byp_ff;
      end
    end
  end

  always_ff @(negedge tck or posedge tap_rst) begin
    if (tap_rst) begin
      ir_ff <= OP_IDCODE;
      upd_ff <= '0;
      upd_tgl_ff <= 1'b0;
      extest_ff <= 1'b0;
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      ir_ff <= nxt_ir;
      upd_ff <= nxt_upd;
      upd_tgl_ff <= nxt_upd_tgl;
      extest_ff <= nxt_extest;
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  assign tdo = tdo_ff;
  assign tdo_oe = tdo_oe_ff;

  // ----------------------------------------------------------------
  // core clock: output pin mux
  // ----------------------------------------------------------------
  // latch word is stable for many tck periods after its toggle
  logic ext_m_ff, ext_s_ff, tgl_m_ff, tgl_s_ff, tgl_d_ff;
  logic [NOUT-1:0] word_ff, nxt_word, nxt_pad_out;

  always_comb begin
    nxt_word = word_ff;
    if (tgl_s_ff ^ tgl_d_ff) begin
      nxt_word = upd_ff;
    end
    nxt_pad_out = ext_s_ff ? word_ff : core_out;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_m_ff <= 1'b0;
      ext_s_ff <= 1'b0;
      tgl_m_ff <= 1'b0;
      tgl_s_ff <= 1'b0;
      tgl_d_ff <= 1'b0;
      word_ff <= '0;
      pad_out_ff <= '0;
    end else begin
      ext_m_ff <= extest_ff;
      ext_s_ff <= ext_m_ff;
      tgl_m_ff <= upd_tgl_ff;
      tgl_s_ff <= tgl_m_ff;
      tgl_d_ff <= tgl_s_ff;
      word_ff <= nxt_word;
      pad_out_ff <= nxt_pad_out;
    end
  end

  assign pad_out = pad_out_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  five_high_tlr_a: assert property (
    @(posedge tck) disable iff (tap_rst)
    hi_cnt_ff == HI_CNT_TLR |-> state_ff == S_TLR)
    else $error("five tms highs did not reach reset state");

  reset_ir_id_a: assert property (
    @(posedge tck) disable iff (tap_rst)
    state_ff == S_TLR && $past(state_ff) == S_TLR |-> ir_ff == OP_IDCODE)
    else $error("instruction not id in reset state");

  capture_ir_a: assert property (
    @(posedge tck) disable iff (tap_rst)
    $past(state_ff) == S_CAP_IR |-> ir_sr_ff == IR_CAPTURE)
    else $error("capture-ir pattern wrong");

  shift_ir_a: assert property (
    @(posedge tck) disable iff (tap_rst)
    $past(state_ff) == S_SH_IR |->
      ir_sr_ff == {$past(tdi), $past(ir_sr_ff[IR_W-1:1])})
    else $error("instruction shift wrong");

  update_ir_a: assert property (
    @(posedge tck) disable iff (tap_rst)
    state_ff == S_UPD_IR ##1 state_ff != S_TLR |-> ir_ff == $past(ir_sr_ff))
    else $error("update-ir did not load instruction");

  pause_hold_a: assert property (
    @(posedge tck) disable iff (tap_rst)
    $past(state_ff) == S_PA_DR || $past(state_ff) == S_PA_IR |->
      $stable(bsr_ff) && $stable(id_ff) && $stable(ir_sr_ff))
    else $error("shift path moved during pause");

  bypass_delay_a: assert property (
    @(posedge tck) disable iff (tap_rst)
    $past(state_ff) == S_SH_DR && dr_sel(ir_ff) == SEL_BYP |->
      byp_ff == $past(tdi))
    else $error("bypass stage does not follow tdi");

  capture_id_a: assert property (
    @(posedge tck) disable iff (tap_rst)
    $past(state_ff) == S_CAP_DR && ir_ff == OP_IDCODE && $stable(ir_ff)
      |-> id_ff == ID_CODE)
    else $error("id code not captured");

  single_chain_a: assert property (
    @(posedge tck) disable iff (tap_rst)
    $past(state_ff) == S_CAP_DR && ir_ff == OP_SINGLE_CHAIN
      && $stable(ir_ff) |-> bsr_ff[ID_W-1:0] == ID_CODE)
    else $error("boundary chain did not capture id code");

  update_latch_a: assert property (
    @(posedge tck) disable iff (tap_rst)
    state_ff == S_UPD_DR && dr_sel(ir_ff) == SEL_BSR |=>
      upd_ff == $past(bsr_ff[BSR_W-1:NIN]))
    else $error("update latch not loaded from chain");

  tdo_enable_a: assert property (
    @(posedge tck) disable iff (tap_rst)
    tdo_oe_ff == (state_ff == S_SH_DR || state_ff == S_SH_IR))
    else $error("tdo enable outside shift states");

endmodule

`default_nettype wire

// ---- jtb_tester.sv ----
// behavioural boundary-scan tester on the far side of the test port
`timescale 1ns/1ps
`default_nettype none

module jtb_tester (
  output logic tck, // test clock, still between frames
  output logic tms, // mode select
  output logic tdi, // serial data, pulled high when idle
  output logic trst_n, // test reset
  input wire logic tdo, // serial data back
  input wire logic tdo_oe // tdo driven
);
  logic oe_seen;

  initial begin
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b1;
    trst_n = 1'b0;
  end

  // -------------------------------------------------------------
  // one tck period, tdo taken just before the rising edge
  // -------------------------------------------------------------
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #62.5;
    o = tdo_oe ? tdo : 1'b1; // released line reads as pulled high
    oe_seen = tdo_oe;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask

  // full scan from run-test-idle back to run-test-idle
  // pz: bit after which the scan rests in pause, -1 for none
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oe_all,
                      input int pz);
    logic o;
    dout = '0;
    oe_all = 1'b1;
    tick(1'b1, 1'b1, o);
    if (ir) begin
      tick(1'b1, 1'b1, o);
    end
    tick(1'b0, 1'b1, o);
    tick(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1 || i == pz, din[i], o);
      dout[i] = o;
      oe_all &= oe_seen;
      if (i == pz && i != n - 1) begin
        tick(1'b0, 1'b1, o);
        tick(1'b0, 1'b1, o);
        tick(1'b1, 1'b1, o);
        tick(1'b0, 1'b1, o);
      end
    end
    tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
  endtask

  // run-test-idle to shift-dr, left there
  task automatic to_shift_dr();
    logic o;
    tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
    tick(1'b0, 1'b1, o);
  endtask

  task automatic tlr5();
    logic o;
    repeat (5) tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
  endtask

  task automatic reset_port();
    logic o;
    trst_n = 1'b0;
    #100;
    trst_n = 1'b1;
    tick(1'b0, 1'b1, o);
  endtask
endmodule

`default_nettype wire

// ---- tb_top.sv ----
// self-checking testbench for the jtag test access port
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import jtb_pkg::*;
  logic clk_sys, rst, tck, trst_n, tms, tdi, tdo, tdo_oe, oe;
  logic [15:0] pad_in, core_out, pad_out;
  logic [31:0] got;
  int err_count, n_tests;

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  jtb_tap #(.NIN(16), .NOUT(16), .ID_CODE(ID_DEFAULT)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .tck(tck), .trst_n(trst_n), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in),
    .core_out(core_out), .pad_out(pad_out));

  jtb_tester u_tst (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe(tdo_oe));

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wclk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic load_ir(input logic [2:0] op);
    u_tst.scan(1'b1, 3, {29'h0, op}, got, oe, -1);
    check(got, {29'h0, IR_CAPTURE});
    check(oe, 1'b1);
  endtask

  task automatic dr(input int n, input logic [31:0] din);
    u_tst.scan(1'b0, n, din, got, oe, -1);
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_idcode();
    dr(32, 32'h0);
    check(got, ID_DEFAULT);
    check(tdo_oe, 1'b0);
  endtask

  task automatic t_bypass();
    load_ir(OP_BYPASS);
    dr(8, 32'hB5);
    check(got, 32'h6A);
    load_ir(3'h5);
    dr(8, 32'hB5);
    check(got, 32'h6A);
    u_tst.to_shift_dr();
    u_tst.tlr5();
    t_idcode();
    load_ir(OP_BYPASS);
    u_tst.to_shift_dr();
    u_tst.reset_port();
    t_idcode();
  endtask

  task automatic t_sample();
    pad_in = 16'h1234;
    core_out = 16'hC3A5;
    wclk(20);
    check(pad_out, 16'hC3A5);
    load_ir(OP_SAMPLE);
    dr(32, 32'h5AF0_0F0F);
    check(got, 32'hC3A5_1234);
    wclk(10);
    check(pad_out, 16'hC3A5);
  endtask

  task automatic t_extest();
    load_ir(OP_EXTEST);
    wclk(10);
    check(pad_out, 16'h5AF0);
    pad_in = 16'h0F1E;
    wclk(20);
    dr(32, 32'h9C00_0000);
    check(got[15:0], 16'h0F1E);
    check(got[31:16], 16'h5AF0);
    wclk(10);
    check(pad_out, 16'h9C00);
  endtask

  task automatic t_chain();
    load_ir(OP_SINGLE_CHAIN);
    dr(32, 32'h0);
    check(got, ID_DEFAULT);
    wclk(10);
    check(pad_out, 16'hC3A5);
  endtask

  task automatic t_pause();
    u_tst.scan(1'b1, 3, {29'h0, OP_IDCODE}, got, oe, 1);
    check(got, {29'h0, IR_CAPTURE});
    check(oe, 1'b1);
    u_tst.scan(1'b0, 32, 32'h0, got, oe, 12);
    check(got, ID_DEFAULT);
    check(oe, 1'b1);
  endtask

  initial begin
    rst = 1'b1;
    pad_in = '0;
    core_out = '0;
    err_count = 0;
    n_tests = 0;
    wclk(12);
    check(tdo_oe, 1'b0);
    rst = 1'b0;
    u_tst.reset_port();
    t_idcode();
    t_bypass();
    t_sample();
    t_extest();
    t_chain();
    t_pause();
    complete_run();
  end

  initial begin
    #300000;
    err_count++;
    complete_run();
  end
endmodule

`default_nettype wire
